// [core/dsl_cfg.svh]
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH

// Initial sector of the first group in each column, rewritable media
`define DSL_RW_INFO_OL  21'h0f3965
`define DSL_RW_INFO_OG  21'h102792
`define DSL_RW_INFO_IL  21'h102650
`define DSL_RW_INFO_IG  21'h11147d
`define DSL_RW_DEF_OL   21'h0f397c
`define DSL_RW_DEF_OG   21'h1027a9
`define DSL_RW_DEF_IL   21'h102667
`define DSL_RW_DEF_IG   21'h111494

// Initial sector of the first group in each column, write-once media
`define DSL_WO_INFO_OL  21'h107977
`define DSL_WO_INFO_OG  21'h116d19
`define DSL_WO_INFO_IL  21'h116bf3
`define DSL_WO_INFO_IG  21'h125f95
`define DSL_WO_DEF_OL   21'h10798c
`define DSL_WO_DEF_OG   21'h116d2e
`define DSL_WO_DEF_IL   21'h116c08
`define DSL_WO_DEF_IG   21'h125faa

// Layout and sector constants
`define DSL_GROUPS      4'h5
`define DSL_ZONE_SPAN   21'h000014
`define DSL_TOP_SLOT    2'h3
`define DSL_LBA_OFFSET  24'h7a1200
`define DSL_RECORD_LEN  14'h2000
`define DSL_CNT_MAX     14'h3fff

`endif

// [core/dsl_locator.sv]
`timescale 1ns/1ps
`include "dsl_cfg.svh"
module dsl_locator #(
	parameter int          NGROUP = 10,
	parameter logic [13:0] REC_LEN = `DSL_RECORD_LEN
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        write_once_media,
	input  wire logic        scan_start,
	input  wire logic        scan_area,
	output logic             scan_busy,
	output logic             scan_done,
	output logic             scan_error,
	output logic             rd_req,
	output logic [20:0]      rd_pba,
	output logic [23:0]      rd_lba,
	input  wire logic        rd_done,
	input  wire logic        rd_written,
	input  wire logic        rd_err,
	input  wire logic        rd_byte_valid,
	input  wire logic [23:0] rd_lba_seen,
	input  wire logic [3:0]  sel_group,
	output logic [20:0]      sel_pba,
	output logic             sel_valid,
	input  wire logic        wr_req,
	input  wire logic [20:0] wr_pba,
	input  wire logic        format_active,
	input  wire logic        disk_formatted,
	output logic             wr_allow,
	output logic             wr_no_remap,
	output logic             def_rewrite_due
);
	// Base of one column of groups for the given media, area, copy and track type
	function automatic logic [20:0] dsl_base(input logic wo, input logic defn,
			input logic inner, input logic groove);
		logic [3:0] key;
		key = {wo, defn, inner, groove};
		case (key)
			4'h0: dsl_base = `DSL_RW_INFO_OL;
			4'h1: dsl_base = `DSL_RW_INFO_OG;
			4'h2: dsl_base = `DSL_RW_INFO_IL;
			4'h3: dsl_base = `DSL_RW_INFO_IG;
			4'h4: dsl_base = `DSL_RW_DEF_OL;
			4'h5: dsl_base = `DSL_RW_DEF_OG;
			4'h6: dsl_base = `DSL_RW_DEF_IL;
			4'h7: dsl_base = `DSL_RW_DEF_IG;
			4'h8: dsl_base = `DSL_WO_INFO_OL;
			4'h9: dsl_base = `DSL_WO_INFO_OG;
			4'ha: dsl_base = `DSL_WO_INFO_IL;
			4'hb: dsl_base = `DSL_WO_INFO_IG;
			4'hc: dsl_base = `DSL_WO_DEF_OL;
			4'hd: dsl_base = `DSL_WO_DEF_OG;
			4'he: dsl_base = `DSL_WO_DEF_IL;
			default: dsl_base = `DSL_WO_DEF_IG;
		endcase
	endfunction

	// Address lies in any of the four columns of an area
	function automatic logic dsl_in_area(input logic [20:0] a, input logic wo,
			input logic defn);
		logic hit;
		logic [20:0] b;
		hit = 1'b0;
		for (int k = 0; k < 4; k++) begin
			b = dsl_base(wo, defn, k[1], k[0]);
			if (a >= b && a < b + `DSL_ZONE_SPAN) begin
				hit = 1'b1;
			end
		end
		dsl_in_area = hit;
	endfunction

	dsl_pkg::dsl_state_t state;
	dsl_pkg::dsl_state_t next_state;
	logic [3:0]  grp;
	logic [1:0]  slot;
	logic        copy;
	logic        area;
	logic [13:0] byte_cnt;
	logic        fmt_d;
	logic        mem_we;
	logic [21:0] mem_wdata;
	logic [21:0] mem_rdata;

	// Group split: first five land, next five groove
	wire        grp_groove = (grp >= `DSL_GROUPS);
	wire [3:0]  grp_col    = grp_groove ? grp - `DSL_GROUPS : grp;
	wire [20:0] probe_pba  = dsl_base(write_once_media, area, copy, grp_groove)
		+ {15'h0000, grp_col, 2'h0} + {19'h00000, slot};
	// A slot counts only when written, readable, carrying the right address and a full record
	wire        rec_full   = (byte_cnt == REC_LEN);
	wire        lba_ok     = (rd_lba_seen == rd_lba);
	wire        slot_hit   = rd_written && !rd_err && lba_ok && rec_full;
	wire        done_ev    = (state == dsl_pkg::DSL_WAIT) && rd_done;
	wire        last_try   = (slot == 2'h0) && copy;
	wire        last_grp   = (grp == 4'(NGROUP - 1));

	// Scan state machine: slots probed from highest down, outer copy before inner
	always_comb begin
		next_state = state;
		case (state)
			dsl_pkg::DSL_IDLE: begin
				if (scan_start) begin
					next_state = dsl_pkg::DSL_ISSUE;
				end
			end
			dsl_pkg::DSL_ISSUE: next_state = dsl_pkg::DSL_WAIT;
			dsl_pkg::DSL_WAIT: begin
				if (rd_done) begin
					next_state = dsl_pkg::DSL_NEXT;
				end
			end
			dsl_pkg::DSL_NEXT: begin
				if (mem_we && last_grp) begin
					next_state = dsl_pkg::DSL_DONE;
				end else begin
					next_state = dsl_pkg::DSL_ISSUE;
				end
			end
			default: next_state = dsl_pkg::DSL_IDLE;
		endcase
	end

	logic hit_q;
	logic fail_q;

	// Capture outcome of the finished probe for the NEXT step
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hit_q  <= 1'b0;
			fail_q <= 1'b0;
		end else if (done_ev) begin
			hit_q  <= slot_hit;
			fail_q <= !slot_hit && last_try;
		end
	end

	// Result written once per group: hit stores address, exhaustion stores invalid
	assign mem_we    = (state == dsl_pkg::DSL_NEXT) && (hit_q || fail_q);
	assign mem_wdata = {hit_q, rd_pba};

	// Position walk through groups, copies and slots
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= dsl_pkg::DSL_IDLE;
			grp   <= 4'h0;
			slot  <= `DSL_TOP_SLOT;
			copy  <= 1'b0;
			area  <= 1'b0;
		end else begin
			state <= next_state;
			if (state == dsl_pkg::DSL_IDLE && scan_start) begin
				grp  <= 4'h0;
				slot <= `DSL_TOP_SLOT;
				copy <= 1'b0;
				area <= scan_area;
			end else if (state == dsl_pkg::DSL_NEXT) begin
				if (mem_we) begin
					grp  <= grp + 4'h1;
					slot <= `DSL_TOP_SLOT;
					copy <= 1'b0;
				end else if (slot != 2'h0) begin
					slot <= slot - 2'h1;
				end else begin
					slot <= `DSL_TOP_SLOT;
					copy <= 1'b1;
				end
			end
		end
	end

	// Read request toward the channel; fixed address, never remapped
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_req <= 1'b0;
			rd_pba <= 21'h000000;
			rd_lba <= 24'h000000;
		end else if (state == dsl_pkg::DSL_ISSUE) begin
			rd_req <= 1'b1;
			rd_pba <= probe_pba;
			rd_lba <= 24'(probe_pba) + `DSL_LBA_OFFSET;
		end else if (done_ev) begin
			rd_req <= 1'b0;
		end
	end

	// Payload byte counter; saturates so an overlong record never wraps to a match
	always_ff @(posedge core_clk) begin
		if (srst || state == dsl_pkg::DSL_ISSUE) begin
			byte_cnt <= 14'h0000;
		end else if (state == dsl_pkg::DSL_WAIT && rd_byte_valid
				&& byte_cnt != `DSL_CNT_MAX) begin
			byte_cnt <= byte_cnt + 14'h0001;
		end
	end

	// Scan status; error is sticky until the next scan starts
	always_ff @(posedge core_clk) begin
		if (srst) begin
			scan_done  <= 1'b0;
			scan_error <= 1'b0;
		end else begin
			scan_done <= (state == dsl_pkg::DSL_DONE);
			if (mem_we && fail_q) begin
				scan_error <= 1'b1;
			end else if (state == dsl_pkg::DSL_IDLE && scan_start) begin
				scan_error <= 1'b0;
			end
		end
	end

	assign scan_busy = (state != dsl_pkg::DSL_IDLE);

	dsl_sel_mem #(
		.WIDTH(22),
		.DEPTH(NGROUP),
		.AW   (4)
	) u_sel_mem (
		.core_clk(core_clk),
		.srst    (srst),
		.we      (mem_we),
		.waddr   (grp),
		.wdata   (mem_wdata),
		.raddr   (sel_group),
		.rdata   (mem_rdata)
	);

	assign sel_pba   = mem_rdata[20:0];
	assign sel_valid = mem_rdata[21];

	// Write gate: info zones never, definition zones only in their format window
	wire wr_in_info = dsl_in_area(wr_pba, write_once_media, 1'b0);
	wire wr_in_def  = dsl_in_area(wr_pba, write_once_media, 1'b1);
	wire def_block  = write_once_media ? disk_formatted : !format_active;
	assign wr_allow    = wr_req && !wr_in_info && !(wr_in_def && def_block);
	assign wr_no_remap = wr_in_info || wr_in_def;

	// Rewrite reminder raised on format start of rewritable media; a new start beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fmt_d           <= 1'b0;
			def_rewrite_due <= 1'b0;
		end else begin
			fmt_d <= format_active;
			if (format_active && !fmt_d && !write_once_media) begin
				def_rewrite_due <= 1'b1;
			end else if (wr_allow && wr_in_def) begin
				def_rewrite_due <= 1'b0;
			end
		end
	end

	sequence s_probe_miss;
		done_ev && !slot_hit && (slot != 2'h0);
	endsequence

	sequence s_exhausted;
		done_ev && !slot_hit && last_try;
	endsequence

	property p_hit_store;
		logic [20:0] p;
		@(posedge core_clk) disable iff (srst)
		(done_ev && slot_hit, p = rd_pba) |=> mem_we && mem_wdata[21] && mem_wdata[20:0] == p;
	endproperty
	a_hit_store: assert property (p_hit_store) else $error("hit slot not stored");

	property p_step_down;
		logic [1:0] s;
		@(posedge core_clk) disable iff (srst)
		(s_probe_miss, s = slot) |=> ##1 (slot == s - 2'h1) ##1 rd_req;
	endproperty
	a_step_down: assert property (p_step_down) else $error("no step to lower slot");

	property p_lba;
		@(posedge core_clk) disable iff (srst)
		rd_req |-> rd_lba == 24'(rd_pba) + `DSL_LBA_OFFSET;
	endproperty
	a_lba: assert property (p_lba) else $error("control address mismatch");

	property p_in_zone;
		@(posedge core_clk) disable iff (srst)
		rd_req |-> dsl_in_area(rd_pba, write_once_media, area);
	endproperty
	a_in_zone: assert property (p_in_zone) else $error("probe outside zone");

	property p_info_ro;
		@(posedge core_clk) disable iff (srst)
		wr_in_info |-> !wr_allow && wr_no_remap;
	endproperty
	a_info_ro: assert property (p_info_ro) else $error("info zone write let through");

	property p_wo_def;
		@(posedge core_clk) disable iff (srst)
		write_once_media && disk_formatted && wr_in_def |-> !wr_allow;
	endproperty
	a_wo_def: assert property (p_wo_def) else $error("definition write after format");

	// Set wins over a same-cycle clear, so the reminder is up one edge after the start
	property p_fmt_due;
		@(posedge core_clk) disable iff (srst)
		$rose(format_active) && !write_once_media |=> def_rewrite_due;
	endproperty
	a_fmt_due: assert property (p_fmt_due) else $error("rewrite reminder missing");

	property p_error;
		@(posedge core_clk) disable iff (srst)
		s_exhausted |=> (mem_we && !mem_wdata[21]) ##1 scan_error;
	endproperty
	a_error: assert property (p_error) else $error("exhausted group not flagged");

	property p_short_rec;
		@(posedge core_clk) disable iff (srst)
		done_ev && byte_cnt != REC_LEN |=> !(mem_we && mem_wdata[21]);
	endproperty
	a_short_rec: assert property (p_short_rec) else $error("short record accepted");
endmodule // dsl_locator

// [core/dsl_pkg.sv]
package dsl_pkg;
	typedef enum logic [2:0] {
		DSL_IDLE,
		DSL_ISSUE,
		DSL_WAIT,
		DSL_NEXT,
		DSL_DONE
	} dsl_state_t;
endpackage

// [core/dsl_sel_mem.sv]
`timescale 1ns/1ps
module dsl_sel_mem #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 10,
	parameter int AW    = 4
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Entries clear on reset so an unscanned group reads as not valid
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read; out-of-range index reads zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (int'(raddr) < DEPTH) begin
			rdata <= mem[raddr];
		end else begin
			rdata <= '0;
		end
	end
endmodule // dsl_sel_mem

// [verification/dsl_disk_model.sv]
`timescale 1ns/1ps
// Recorded medium behind the read channel.
// Sector state st: 1 written, 2 written but unreadable, 3 written with bad control bytes,
// 4 written with a record one byte short
module dsl_disk_model #(
	parameter int REC = 8
) (
	input  wire logic        core_clk,
	input  wire logic        rd_req,
	input  wire logic [20:0] rd_pba,
	output logic             rd_done,
	output logic             rd_written,
	output logic             rd_err,
	output logic             rd_byte_valid,
	output logic [23:0]      rd_lba_seen
);
	byte st[int];
	int  k;
	int  nb;

	// One probe at a time; released lines show the inverse of their last value
	initial begin
		{rd_done, rd_written, rd_err, rd_byte_valid, rd_lba_seen} = '0;
		forever begin
			@(posedge core_clk);
			if (rd_req === 1'b1) begin
				k = rd_pba;
				nb = (st.exists(k) && st[k] == 4) ? REC - 1 : REC;
				// Odd sectors answer slowly so probe spacing varies
				repeat (rd_pba[0] ? 6 : 1) @(posedge core_clk);
				for (int n = 0; n < nb; n++) begin
					#1 rd_byte_valid = 1'b1;
					@(posedge core_clk);
				end
				#1 rd_byte_valid = 1'b0;
				rd_done = 1'b1;
				rd_written = st.exists(k);
				rd_err = st.exists(k) && st[k] == 2;
				rd_lba_seen = 24'(k + 8000000) ^ {23'h0, st.exists(k) && st[k] == 3};
				@(posedge core_clk);
				#1 rd_done = 1'b0;
				{rd_written, rd_err} = ~{rd_written, rd_err};
				rd_lba_seen = ~rd_lba_seen;
			end
		end
	end
endmodule // dsl_disk_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic        core_clk = 1'b0, srst = 1'b1, write_once_media = 1'b0;
	logic        scan_start = 1'b0, scan_area = 1'b0, wr_req = 1'b0;
	logic        format_active = 1'b0, disk_formatted = 1'b0;
	logic        scan_busy, scan_done, scan_error, rd_req, sel_valid;
	logic        rd_done, rd_written, rd_err, rd_byte_valid;
	logic        wr_allow, wr_no_remap, def_rewrite_due;
	logic [3:0]  sel_group = 4'h0;
	logic [20:0] rd_pba, sel_pba, wr_pba = 21'h000000;
	logic [23:0] rd_lba, rd_lba_seen;
	int          mismatches = 0, total_checks = 0, cycles = 0;
	// First initial sector per column, indexed {write_once, definition, inner, groove}
	int          base_tab[16] = '{997733, 1058706, 1058384, 1119357, 997756, 1058729,
		1058407, 1119380, 1079671, 1142041, 1141747, 1204117, 1079692, 1142062,
		1141768, 1204138};

	always #20 core_clk = ~core_clk;

	// Record length shortened so a scan stays brief
	dsl_locator #(.REC_LEN(14'h0008)) i_dut (.core_clk, .srst, .write_once_media,
		.scan_start, .scan_area, .scan_busy, .scan_done, .scan_error, .rd_req, .rd_pba,
		.rd_lba, .rd_done, .rd_written, .rd_err, .rd_byte_valid, .rd_lba_seen, .sel_group,
		.sel_pba, .sel_valid, .wr_req, .wr_pba, .format_active, .disk_formatted, .wr_allow,
		.wr_no_remap, .def_rewrite_due);

	dsl_disk_model #(.REC(8)) i_disk (.core_clk, .rd_req, .rd_pba, .rd_done,
		.rd_written, .rd_err, .rd_byte_valid, .rd_lba_seen);

	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [23:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, exp);
		check({23'h0, got}, {23'h0, exp});
	endtask

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	function automatic int physical_block_address(input logic wo, defn, inr, input int g, s);
		return base_tab[{wo, defn, inr, g > 4}] + 4 * (g % 5) + s;
	endfunction

	function automatic logic in_zone(input int p);
		int b;
		for (int k = 0; k < 4; k++) begin
			b = base_tab[{write_once_media, scan_area, 2'(k)}];
			if (p >= b && p < b + 20) return 1'b1;
		end
		return 1'b0;
	endfunction

	// A second start in mid-scan must be ignored; busy falls as done pulses
	task automatic run_scan(input logic wo, ar);
		int n;
		n = 0;
		write_once_media = wo;
		scan_area = ar;
		scan_start = 1'b1;
		tick();
		scan_start = 1'b0;
		check1(scan_busy, 1'b1);
		while (scan_done !== 1'b1 && n < 5000) begin
			scan_start = (n == 4);
			tick();
			n++;
		end
		check1(scan_busy, 1'b0);
		check1(n < 5000, 1'b1);
	endtask

	task automatic check_sel(input int g, input logic v, input int p);
		sel_group = 4'(g);
		tick();
		tick();
		check1(sel_valid, v);
		if (v) check(sel_pba, 24'(p));
	endtask

	// Reminder rises at the first edge that sees the format start, holds until a definition write
	task automatic scen_due();
		format_active = 1'b1;
		tick();
		check1(def_rewrite_due, 1'b1);
		tick();
		check1(def_rewrite_due, 1'b1);
		wr_req = 1'b1;
		wr_pba = 21'(physical_block_address(0, 1, 1, 2, 1));
		tick();
		check1(def_rewrite_due, 1'b0);
		{wr_req, format_active} = 2'b00;
	endtask

	// Outer copy of group 0 degrades slot by slot; group 3 is blank everywhere
	task automatic scen_fallback();
		i_disk.st.delete();
		for (int g = 0; g < 10; g++)
			if (g != 3) begin
				i_disk.st[physical_block_address(0, 0, 1, g, 0)] = 1;
				i_disk.st[physical_block_address(0, 0, 1, g, 1)] = 1;
			end
		for (int s = 0; s < 4; s++)
			i_disk.st[physical_block_address(0, 0, 0, 0, s)] = 8'(1 + s);
		run_scan(1'b0, 1'b0);
		check1(scan_error, 1'b1);
		check_sel(0, 1'b1, physical_block_address(0, 0, 0, 0, 0));
		check_sel(3, 1'b0, 0);
		check_sel(7, 1'b1, physical_block_address(0, 0, 1, 7, 1));
	endtask

	// Each media and area pair, with slots up to c written in both copies
	task automatic scen_pick();
		for (int c = 0; c < 4; c++) begin
			i_disk.st.delete();
			for (int g = 0; g < 10; g++)
				for (int s = 0; s <= c; s++) begin
					i_disk.st[physical_block_address(c[0], c[1], 0, g, s)] = 1;
					i_disk.st[physical_block_address(c[0], c[1], 1, g, s)] = 1;
				end
			run_scan(c[0], c[1]);
			check1(scan_error, 1'b0);
			for (int g = 0; g < 10; g++)
				check_sel(g, 1'b1, physical_block_address(c[0], c[1], 0, g, c));
		end
	endtask

	task automatic wcase(input logic wo, fa, df, input int p, input logic al, nr);
		{write_once_media, format_active, disk_formatted, wr_req} = {wo, fa, df, 1'b1};
		wr_pba = 21'(p);
		tick();
		check1(wr_allow, al);
		check1(wr_no_remap, nr);
	endtask

	task automatic scen_gate();
		wcase(0, 1, 0, physical_block_address(0, 0, 0, 2, 1), 0, 1);
		wcase(1, 0, 0, physical_block_address(1, 0, 1, 7, 0), 0, 1);
		wcase(0, 0, 0, physical_block_address(0, 1, 0, 1, 3), 0, 1);
		wcase(0, 1, 0, physical_block_address(0, 1, 1, 9, 2), 1, 1);
		wcase(1, 0, 1, physical_block_address(1, 1, 0, 4, 3), 0, 1);
		wcase(1, 0, 0, physical_block_address(1, 1, 1, 5, 0), 1, 1);
		wcase(0, 0, 0, 997753, 1, 0);
		wr_req = 1'b0;
	endtask

	// Every probe carries its control address and stays in a fixed zone
	always @(posedge core_clk)
		if (rd_req === 1'b1 && rd_done === 1'b1) begin
			check(rd_lba, rd_pba + 24'd8000000);
			check1(in_zone(rd_pba), 1'b1);
		end

	// Hang guard, far beyond the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk);
		#1 srst = 1'b0;
		check1(rd_req, 1'b0);
		check1(scan_busy, 1'b0);
		check1(def_rewrite_due, 1'b0);
		scen_due();
		scen_fallback();
		scen_pick();
		scen_gate();
		complete_run();
	end
endmodule // tb_top
